// ---- scd_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_bus_model (
	input  wire logic       clk_i,
	input  wire logic       scl_oe_i,
	input  wire logic       sda_oe_i,
	input  wire logic       scl_i,
	input  wire logic [1:0] mode_i,
	input  wire logic [3:0] hold_i,
	output var  logic       scl_pull_o,
	output var  logic       sda_pull_o
);
	logic [3:0] st_q = 4'h0;
	logic [2:0] hi_q;
	// stretch after release, then collide on command
	always @(posedge clk_i) begin
		st_q <= scl_oe_i ? hold_i : ((st_q != 4'h0) ? st_q - 4'h1 : st_q);
		hi_q <= (!sda_oe_i || (!scl_i && hi_q != 3'h6)) ? 3'h0 : ((hi_q == 3'h6) ? hi_q : hi_q + 3'h1);
		scl_pull_o <= scl_oe_i || st_q > 4'h1 || (mode_i == 2'h2 && hi_q == 3'h6);
		sda_pull_o <= mode_i == 2'h1 && (sda_oe_i || sda_pull_o);
	end
endmodule // scd_bus_model
`default_nettype wire

// ---- scd_defines.vh ----
`ifndef SCD_DEFINES_VH
`define SCD_DEFINES_VH
// register byte offsets on the wishbone bus
`define SCD_OFS_RELOAD   4'h0
`define SCD_OFS_CTRL1    4'h4
`define SCD_OFS_CTRL2    4'h8
`define SCD_OFS_STATUS   4'hC
// control one fields
`define SCD_C1_ENABLE    5
// control two fields
`define SCD_C2_STOP_REQ  2
// status fields
`define SCD_ST_STOP_SEEN 4
`define SCD_ST_COLL      0
// reset values
`define SCD_RELOAD_RST   8'h09
`define SCD_CTRL1_RST    8'h00
`define SCD_CTRL2_RST    8'h00
// reload field width
`define SCD_RELOAD_MSB   6
`endif

// ---- scd_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module scd_monitor (
	// bus and lines of the top module
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic serial_clock_line_i,
	input wire logic serial_clock_line_oe_o,
	input wire logic serial_data_line_i,
	input wire logic serial_data_line_oe_o,
	input wire logic serial_clock_line_o,
	input wire logic serial_data_line_o
);
	wire c = serial_clock_line_i, d = serial_data_line_i;
	wire cq = serial_clock_line_oe_o, dq = serial_data_line_oe_o;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// clock released then held low by another party
	sequence s_str;
		$fell(cq) ##1 !c[*4];
	endsequence
	// stop order and aborts
	a_data_first: assert property ($rose(dq) |-> cq) else $error("data before clock");
	a_clk_after: assert property ($fell(cq) |-> dq && !$past(d, 2)) else $error("clock early");
	a_stretch_wait: assert property (s_str |-> dq) else $error("stretch ignored");
	a_count_hold: assert property ($rose(c) && dq |-> dq[*8]) else $error("count short");
	a_coll_rel: assert property (dq && !cq && $fell(c) |-> ##[1:4] !dq && !cq) else $error("no abort");
	a_rel_order: assert property ($fell(dq) |-> !cq) else $error("data early");
	a_lines_low: assert property (!serial_clock_line_o && !serial_data_line_o) else $error("line driven high");
	// bus answer timing
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
	a_ack_one: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
endmodule // scd_monitor
`default_nettype wire

// ---- scd_stop_collision.v ----
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.vh"

// Operation
// - the stop sequence begins with data driven low and the clock is released only after data reads back low.
// - after releasing the clock the block waits until it reads the clock high, allowing stretching.
// - once the clock reads high the reload counter loads bits 6:0 of the reload register and counts to zero.
// - after data is released and the counter expires, data reading low is a bus collision.
// - a clock reading low after it has read high but before data is allowed high is a bus collision.
// - without collision data is released at counter expiry, one reload period after the clock reads high.
// - any collision sets the bus collision flag and returns the port to idle.
// - a stop collision aborts the sequence, releases both lines and clears the stop request bit.
module scd_stop_collision (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// open-drain bus lines
	input  wire        serial_clock_line_i,
	output reg         serial_clock_line_o,
	output reg         serial_clock_line_oe_o,
	input  wire        serial_data_line_i,
	output reg         serial_data_line_o,
	output reg         serial_data_line_oe_o
);

	// one-hot states
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_SDALO = 6'h02;
	localparam [5:0] ST_SCLHI = 6'h04;
	localparam [5:0] ST_HOLD  = 6'h08;
	localparam [5:0] ST_SDAHI = 6'h10;
	localparam [5:0] ST_CHECK = 6'h20;

	// sequencer and register state
	reg [5:0] state_q;
	reg [7:0] reload_q;
	reg [7:0] ctrl1_q;
	reg       stop_req_q;
	reg       stop_seen_q;
	reg       coll_q;
	reg [6:0] baud_reload_counter_q;
	// synchroniser stages, first then second flop
	reg       scl_m_q;
	reg       scl_s_q;
	reg       sda_m_q;
	reg       sda_s_q;
	// pull-low requests ahead of the pin registers
	reg       drive_scl_low_q;
	reg       drive_sda_low_q;

	// bus qualifiers and counter decode
	wire enable    = ctrl1_q[`SCD_C1_ENABLE];
	wire wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wb_wr     = wb_req & wb_we_i & wb_sel_i[0];
	wire cnt_zero  = (baud_reload_counter_q == 7'h00);
	wire [6:0] reload_val = reload_q[`SCD_RELOAD_MSB:0];

	// address decode shared by read and write
	function hit;
		input [3:0] adr;
		input [3:0] ofs;
		begin
			hit = (adr == ofs);
		end
	endfunction

	// two-flop synchronisers on pin inputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
		end else begin
			scl_m_q <= serial_clock_line_i;
			scl_s_q <= scl_m_q;
			sda_m_q <= serial_data_line_i;
			sda_s_q <= sda_m_q;
		end
	end

	// bus slave: one-wait-state ack, registered read data
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req && !wb_we_i) begin
				if (hit(wb_adr_i, `SCD_OFS_RELOAD))
					wb_dat_o <= {24'h000000, reload_q};
				else if (hit(wb_adr_i, `SCD_OFS_CTRL1))
					wb_dat_o <= {24'h000000, ctrl1_q};
				else if (hit(wb_adr_i, `SCD_OFS_CTRL2))
					wb_dat_o <= {29'h0, stop_req_q, 2'b00};
				else if (hit(wb_adr_i, `SCD_OFS_STATUS))
					wb_dat_o <= {27'h0, stop_seen_q, 3'b000, coll_q};
			end
		end
	end

	// software-written configuration
	always @(posedge clk_i) begin
		if (rst_i) begin
			reload_q <= `SCD_RELOAD_RST;
			ctrl1_q  <= `SCD_CTRL1_RST;
		end else if (wb_wr) begin
			if (hit(wb_adr_i, `SCD_OFS_RELOAD))
				reload_q <= wb_dat_i[7:0];
			if (hit(wb_adr_i, `SCD_OFS_CTRL1))
				ctrl1_q <= wb_dat_i[7:0];
		end
	end

	// stop sequencer with collision detection
	always @(posedge clk_i) begin
		if (rst_i || !enable) begin
			state_q               <= ST_IDLE;
			stop_req_q            <= 1'b0;
			stop_seen_q           <= 1'b0;
			coll_q                <= 1'b0;
			baud_reload_counter_q <= 7'h00;
			drive_scl_low_q       <= 1'b0;
			drive_sda_low_q       <= 1'b0;
		end else begin
			if (!cnt_zero)
				baud_reload_counter_q <= baud_reload_counter_q - 7'h01;
			// software clears; hardware set below wins
			if (wb_wr && hit(wb_adr_i, `SCD_OFS_STATUS) && wb_dat_i[`SCD_ST_COLL])
				coll_q <= 1'b0;
			if (wb_wr && hit(wb_adr_i, `SCD_OFS_STATUS) && wb_dat_i[`SCD_ST_STOP_SEEN])
				stop_seen_q <= 1'b0;
			// the counter runs down on its own; states reload it
			case (state_q)
				ST_IDLE: begin
					if (wb_wr && hit(wb_adr_i, `SCD_OFS_CTRL2) && wb_dat_i[`SCD_C2_STOP_REQ]) begin
						stop_req_q      <= 1'b1;
						drive_sda_low_q <= 1'b1;
						drive_scl_low_q <= 1'b1;
						state_q         <= ST_SDALO;
					end
				end
				// data must read back low before the clock is let go
				ST_SDALO: begin
					if (!sda_s_q) begin
						drive_scl_low_q <= 1'b0;
						state_q         <= ST_SCLHI;
					end
				end
				// wait out any clock stretching
				ST_SCLHI: begin
					if (scl_s_q) begin
						baud_reload_counter_q <= reload_val;
						state_q               <= ST_HOLD;
					end
				end
				// clock pulled low here means another master
				ST_HOLD: begin
					if (!scl_s_q) begin
						coll_q          <= 1'b1;
						stop_req_q      <= 1'b0;
						drive_sda_low_q <= 1'b0;
						state_q         <= ST_IDLE;
					end else if (cnt_zero) begin
						drive_sda_low_q       <= 1'b0;
						baud_reload_counter_q <= reload_val;
						state_q               <= ST_SDAHI;
					end
				end
				// data is judged through the synchroniser, so reload
				// values under three would sample before the released
				// line has settled
				ST_SDAHI: begin
					if (cnt_zero) begin
						baud_reload_counter_q <= reload_val;
						state_q               <= ST_CHECK;
						if (!sda_s_q) begin
							coll_q     <= 1'b1;
							stop_req_q <= 1'b0;
							state_q    <= ST_IDLE;
						end else begin
							stop_seen_q <= 1'b1;
						end
					end
				end
				// one more period before the request drops
				ST_CHECK: begin
					if (cnt_zero) begin
						stop_req_q <= 1'b0;
						state_q    <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// open-drain pin drivers, registered
	always @(posedge clk_i) begin
		if (rst_i) begin
			serial_clock_line_o    <= 1'b0;
			serial_clock_line_oe_o <= 1'b0;
			serial_data_line_o     <= 1'b0;
			serial_data_line_oe_o  <= 1'b0;
		end else begin
			serial_clock_line_o    <= 1'b0;
			serial_data_line_o     <= 1'b0;
			serial_clock_line_oe_o <= drive_scl_low_q;
			serial_data_line_oe_o  <= drive_sda_low_q;
		end
	end

endmodule // scd_stop_collision
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "scd_defines.vh"
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0, ack, sco_e, sdo_e, scp, sdp;
	logic [3:0]  adr = 4'h0, hold = 4'h2;
	logic [31:0] wdat = 32'h0, rdat;
	logic [1:0]  mode = 2'h0;
	logic [7:0]  rl;
	wire         scl = !(sco_e || scp), sda = !(sdo_e || sdp);
	int          n_fail = 0, num_checks = 0;
	logic [31:0] exq[$];
	scd_stop_collision i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.serial_clock_line_i(scl), .serial_clock_line_o(), .serial_clock_line_oe_o(sco_e),
		.serial_data_line_i(sda), .serial_data_line_o(), .serial_data_line_oe_o(sdo_e));
	scd_bus_model i_bus (.clk_i(clk_i), .scl_oe_i(sco_e), .sda_oe_i(sdo_e), .scl_i(scl), .mode_i(mode),
		.hold_i(hold), .scl_pull_o(scp), .sda_pull_o(sdp));
	// verdict and end of run
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// one classic cycle, a read notes its expected data
	task wb(input logic w, input logic [3:0] a, input logic [31:0] dv);
		int n;
		n = 0;
		if (!w)
			exq.push_back(dv);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= dv;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		cyc <= 1'b0;
		if (ack !== 1'b1) begin
			check("ack", {31'h0, ack}, 32'h1);
			test_done;
		end
		@(posedge clk_i);
	endtask
	// compare each read answer with the oldest note
	always @(posedge clk_i)
		if (ack && cyc && !we)
			check("rdata", rdat, exq.pop_front());
	// one stop sequence against the bus model
	task stop(input logic [1:0] m, input logic [31:0] st);
		int n;
		n = 0;
		mode <= m;
		hold <= 4'($urandom_range(2, 9));
		wb(1'b1, `SCD_OFS_CTRL2, 32'h04);
		do begin
			@(posedge clk_i);
			n++;
		end while ((n < 5 || sdo_e) && n < 300);
		if (n == 300) begin
			check("sda_oe", {31'h0, sdo_e}, 32'h0);
			test_done;
		end
		repeat (40) @(posedge clk_i);
		wb(1'b0, `SCD_OFS_STATUS, st);
		wb(1'b0, `SCD_OFS_CTRL2, 32'h00);
		mode <= 2'h0;
		repeat (20) @(posedge clk_i);
		wb(1'b1, `SCD_OFS_STATUS, 32'h11);
	endtask
	initial forever #12.5 clk_i = !clk_i;
	initial begin
		void'($urandom(80));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, `SCD_OFS_RELOAD, {24'h000000, `SCD_RELOAD_RST});
		rl = 8'($urandom_range(9, 15));
		wb(1'b1, `SCD_OFS_RELOAD, {24'h000000, rl});
		wb(1'b0, `SCD_OFS_RELOAD, {24'h000000, rl});
		wb(1'b0, 4'h1, 32'h00);
		wb(1'b1, `SCD_OFS_CTRL1, 32'h20);
		stop(2'h0, 32'h10);
		stop(2'h1, 32'h01);
		stop(2'h2, 32'h01);
		test_done;
	end
endmodule // tb
bind scd_stop_collision scd_monitor i_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .serial_clock_line_i(serial_clock_line_i), .serial_clock_line_oe_o(serial_clock_line_oe_o),
	.serial_data_line_i(serial_data_line_i), .serial_data_line_oe_o(serial_data_line_oe_o),
	.serial_clock_line_o(serial_clock_line_o), .serial_data_line_o(serial_data_line_o));
`default_nettype wire
